// ===== core/scp_pkg.sv
// constants shared by the serial control port files
package scp_pkg;
  localparam int SCP_BYTE_BITS = 8;
  localparam int SCP_ADDR_BITS = 5;
  localparam logic [2:0] SCP_BIT_MSB = 3'h7;
  localparam int SCP_DIR_BIT = 7;
  localparam int SCP_CNT_HI = 6;
  localparam int SCP_CNT_LO = 5;
  localparam int SCP_ADDR_HI = 4;
  localparam logic [4:0] SCP_ADDR_STEP = 5'h01;
  localparam logic [1:0] SCP_CNT_ONE = 2'h0;
  localparam logic [1:0] SCP_CNT_STEP = 2'h1;
  localparam logic [2:0] SCP_SYNC_RESET = 3'h7;
  localparam logic [4:0] SCP_TEMP_ADDR = 5'h05;
  localparam real SCP_CLOCK_NS = 4.0;
  localparam real SCP_SCLK_MIN_NS = 100.0;
  localparam real SCP_SCLK_TEMP_MIN_NS = 1000.0;
  localparam real SCP_SCLK_PHASE_NS = 40.0;
  localparam real SCP_SCLK_TEMP_PHASE_NS = 400.0;
  localparam int SCP_SCLK_MIN_CYC = int'($ceil(SCP_SCLK_MIN_NS / SCP_CLOCK_NS));
  localparam int SCP_SCLK_PHASE_CYC = int'($ceil(SCP_SCLK_PHASE_NS / SCP_CLOCK_NS));
  localparam int SCP_SCLK_TEMP_PHASE_CYC = int'($ceil(SCP_SCLK_TEMP_PHASE_NS / SCP_CLOCK_NS));
  typedef enum logic [1:0] {
    SCP_IDLE,
    SCP_INSTR,
    SCP_DATA,
    SCP_DONE
  } scp_state_type;
endpackage

// ===== core/scp_sync.sv
// three-stage synchroniser that reports a settled level
module scp_sync
  import scp_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] stage;

  // stage[0] feeds only stage[1]; the two later stages decide the level
  always_ff @(posedge clock) begin
    if (rst) begin
      stage <= {3{INIT}};
    end else begin
      stage <= {stage[1:0], pinIn};
    end
  end

  // level moves only when the second and third stages agree
  always_ff @(posedge clock) begin
    if (rst) begin
      level <= INIT;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (stage[1] == stage[2] && stage[2] != level) begin
        level <= stage[2];
        rise <= stage[2];
        fall <= ~stage[2];
      end
    end
  end
endmodule

// ===== core/scp_shift.sv
// one byte shifter, most significant bit first in both directions
module scp_shift
  import scp_pkg::*;
#(
  parameter int WIDTH = SCP_BYTE_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic shiftIn,
  input wire logic bitIn,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  input wire logic shiftOut,
  output logic [WIDTH-1:0] inWord,
  output logic outBit
);
  logic [WIDTH-1:0] outWord;

  // capture side: new bits enter at the bottom so the first bit ends on top
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      inWord <= '0;
    end else if (shiftIn) begin
      inWord <= {inWord[WIDTH-2:0], bitIn};
    end
  end

  // launch side: load presents the top bit at once
  always_ff @(posedge clock) begin
    if (rst) begin
      outWord <= '0;
      outBit <= 1'b0;
    end else if (load) begin
      outWord <= {loadValue[WIDTH-2:0], 1'b0};
      outBit <= loadValue[WIDTH-1];
    end else if (shiftOut) begin
      outWord <= {outWord[WIDTH-2:0], 1'b0};
      outBit <= outWord[WIDTH-1];
    end
  end
endmodule

// ===== core/scp_serial_port.sv
// serial control port: frame decode, register access strobes and read-back drive
//
// Notes on behaviour
// - four_wire_select chooses between the three-pin and four-pin arrangement.
// - incoming bits are taken on each rising edge of the serial clock.
// - outgoing bits change on each falling edge of the serial clock.
// - the first byte of each frame is the instruction, data bytes follow.
// - instruction bit 7 high asks for a read, low for a write.
// - instruction bits 6 and 5 hold the data byte count less one.
// - instruction bits 4 to 0 hold the first register address.
// - the register address drops by one after each data byte.
// - every byte travels most significant bit first.
// - the data pin stays an input while the instruction byte arrives.
// - in three-pin mode read data goes out on the data pin only, the alarm pin floating.
// - in four-pin mode read data goes out on both the data pin and the alarm pin.
// - in four-pin mode, after the last read bit the alarm pin goes low until the enable rises, then carries the alarm level.
// - every configuration register can be both written and read through the port.
module scp_serial_port
  import scp_pkg::*;
#(
  parameter int ADDR_BITS = SCP_ADDR_BITS,
  parameter int DATA_BITS = SCP_BYTE_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic serial_frame_enable_n,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic alarm_serial_out,
  output logic alarmSerialOe,
  input wire logic alarmLevel,
  input wire logic four_wire_select,
  output logic regWrite,
  output logic regRead,
  output logic [ADDR_BITS-1:0] regAddress,
  output logic [DATA_BITS-1:0] regWriteData,
  input wire logic [DATA_BITS-1:0] regReadData,
  output logic frameActive,
  output logic tempReadActive
);
  // ---------------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------------
  logic sclkLevel;
  logic sclkRise;
  logic sclkFall;
  logic enLevel;
  logic enRise;
  logic enFall;
  logic dataLevel;

  // all three pins pass the same stages, so a data bit and the clock edge
  // that samples it arrive together and pin setup carries through
  // the serial clock is parked high between frames; a wrong guess of the
  // idle level only costs a harmless edge while no frame is open
  scp_sync #(.INIT(1'b1)) syncClock (
    .clock(clock),
    .rst(rst),
    .pinIn(serialClock),
    .level(sclkLevel),
    .rise(sclkRise),
    .fall(sclkFall)
  );
  // the enable starts high so reset release is never taken as a frame start
  scp_sync #(.INIT(1'b1)) syncEnable (
    .clock(clock),
    .rst(rst),
    .pinIn(serial_frame_enable_n),
    .level(enLevel),
    .rise(enRise),
    .fall(enFall)
  );
  // data level only; its edges carry no meaning on their own
  scp_sync #(.INIT(1'b0)) syncData (
    .clock(clock),
    .rst(rst),
    .pinIn(serialDataIn),
    .level(dataLevel),
    .rise(),
    .fall()
  );

  // ---------------------------------------------------------------------
  // frame sequencing
  // ---------------------------------------------------------------------
  scp_state_type state;
  logic [2:0] bitCount;
  logic isRead;
  logic [1:0] bytesLeft;
  logic [ADDR_BITS-1:0] address;
  logic [DATA_BITS-1:0] inWord;
  logic outBit;
  logic byteDone;
  logic loadRead;
  logic shiftRead;
  logic [DATA_BITS-1:0] fullByte;
  logic activeFrame;

  // a rising serial clock with the enable low is a sampled bit
  assign activeFrame = ~enLevel && state != SCP_IDLE;
  assign byteDone = sclkRise && activeFrame && bitCount == SCP_BIT_MSB;
  assign fullByte = {inWord[DATA_BITS-2:0], dataLevel};

  // one shifter serves both directions; capture and launch keep separate registers
  scp_shift #(.WIDTH(DATA_BITS)) shifter (
    .clock(clock),
    .rst(rst),
    .clear(enRise), // partial bits are thrown away on frame end
    .shiftIn(sclkRise && activeFrame),
    .bitIn(dataLevel),
    .load(loadRead),
    .loadValue(regReadData),
    .shiftOut(shiftRead),
    .inWord(inWord), .outBit(outBit)
  );

  // instruction then data bytes; any enable rise drops back to idle
  // clocks beyond the counted bytes land in the done state and change nothing
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= SCP_IDLE;
    end else if (enRise) begin
      state <= SCP_IDLE;
    end else begin
      unique case (state)
        SCP_IDLE: begin
          if (enFall) begin
            state <= SCP_INSTR;
          end
        end
        SCP_INSTR: begin
          if (byteDone) begin
            state <= SCP_DATA;
          end
        end
        SCP_DATA: begin
          if (byteDone && bytesLeft == SCP_CNT_ONE) begin
            state <= SCP_DONE;
          end
        end
        SCP_DONE: begin
          state <= SCP_DONE; // further clocks ignored until the enable rises
        end
      endcase
    end
  end

  // bit position inside the current byte
  // three bits wrap after eight, so each byte restarts the count for free
  always_ff @(posedge clock) begin
    if (rst || enFall || enRise) begin
      bitCount <= '0;
    end else if (sclkRise && activeFrame) begin
      bitCount <= bitCount + 3'h1;
    end
  end

  // instruction fields and the running address
  always_ff @(posedge clock) begin
    if (rst) begin
      isRead <= 1'b0;
      bytesLeft <= '0;
      address <= '0;
    end else if (byteDone && state == SCP_INSTR) begin
      isRead <= fullByte[SCP_DIR_BIT];
      bytesLeft <= fullByte[SCP_CNT_HI:SCP_CNT_LO];
      address <= fullByte[SCP_ADDR_HI:0];
    end else if (byteDone && state == SCP_DATA) begin
      bytesLeft <= bytesLeft - SCP_CNT_STEP;
      address <= address - SCP_ADDR_STEP;
    end
  end

  // ---------------------------------------------------------------------
  // register access strobes
  // ---------------------------------------------------------------------
  logic readPending;

  // a write goes out when a whole data byte lands; reads fetch ahead of each byte
  // fetching ahead leaves the register file a whole serial high phase to answer
  always_ff @(posedge clock) begin
    if (rst) begin
      regWrite <= 1'b0;
      regRead <= 1'b0;
      regAddress <= '0;
      regWriteData <= '0;
    end else begin
      regWrite <= byteDone && state == SCP_DATA && ~isRead;
      regRead <= 1'b0;
      if (byteDone && state == SCP_DATA && ~isRead) begin
        regAddress <= address;
        regWriteData <= fullByte;
      end else if (byteDone && state == SCP_INSTR && fullByte[SCP_DIR_BIT]) begin
        regAddress <= fullByte[SCP_ADDR_HI:0];
        regRead <= 1'b1;
      end else if (byteDone && state == SCP_DATA && isRead && bytesLeft != SCP_CNT_ONE) begin
        regAddress <= address - SCP_ADDR_STEP;
        regRead <= 1'b1;
      end
    end
  end

  // read data is taken into the shifter no sooner than two cycles after the read strobe
  // that matches the one-cycle answer time of the register file
  always_ff @(posedge clock) begin
    if (rst || enRise) begin
      readPending <= 1'b0;
    end else begin
      readPending <= regRead;
    end
  end

  // the byte is loaded on the next falling edge, then shifted on later ones
  logic loadArmed;
  logic firstFallSeen;
  always_ff @(posedge clock) begin
    if (rst || enRise) begin
      loadArmed <= 1'b0;
    end else if (readPending) begin
      loadArmed <= 1'b1;
    end else if (sclkFall) begin
      loadArmed <= 1'b0;
    end
  end
  assign loadRead = loadArmed && sclkFall && state == SCP_DATA;
  assign shiftRead = ~loadArmed && sclkFall && state == SCP_DATA && isRead;

  // ---------------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------------
  // the data pin is an input through the instruction byte and in writes
  // after the final byte the pin keeps its last bit until the enable rises
  always_ff @(posedge clock) begin
    if (rst || enRise) begin
      serialDataOe <= 1'b0;
      serialDataOut <= 1'b0;
      firstFallSeen <= 1'b0;
    end else begin
      if (loadRead) begin
        firstFallSeen <= 1'b1;
      end
      if (state == SCP_INSTR) begin
        serialDataOe <= 1'b0;
      end else if (state == SCP_DATA && isRead && firstFallSeen) begin
        serialDataOe <= 1'b1;
        serialDataOut <= outBit;
      end
    end
  end

  // alarm pin, four-pin mode only: alarm level between frames, read data during reads,
  // low after the last read bit until the frame closes
  // the low tail tells a four-pin host where the read data ended
  logic readEnded;
  always_ff @(posedge clock) begin
    if (rst || enRise) begin
      readEnded <= 1'b0;
    end else if (state == SCP_DONE && isRead && sclkFall) begin
      readEnded <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_serial_out <= 1'b0;
      alarmSerialOe <= 1'b0;
    end else if (~four_wire_select) begin
      alarm_serial_out <= 1'b0;
      alarmSerialOe <= 1'b0; // three-pin: floats during frames
    end else if (state == SCP_IDLE || enLevel) begin
      alarm_serial_out <= alarmLevel; // free pin reports the alarm
      alarmSerialOe <= 1'b1;
    end else if (readEnded) begin
      alarm_serial_out <= 1'b0;
      alarmSerialOe <= 1'b1;
    end else if (state == SCP_DATA && isRead && firstFallSeen) begin
      alarm_serial_out <= outBit;
      alarmSerialOe <= 1'b1;
    end else if (isRead && state != SCP_INSTR) begin
      alarm_serial_out <= alarm_serial_out;
      alarmSerialOe <= alarmSerialOe;
    end else begin
      alarm_serial_out <= 1'b0;
      alarmSerialOe <= 1'b0; // quiet during instruction and writes
    end
  end

  // status: frame in progress and a slow temperature read under way
  // the port cannot stretch the serial clock, so the flag only warns the host side
  always_ff @(posedge clock) begin
    if (rst) begin
      frameActive <= 1'b0;
      tempReadActive <= 1'b0;
    end else begin
      frameActive <= activeFrame;
      tempReadActive <= activeFrame && isRead && state != SCP_INSTR
                        && regAddress == SCP_TEMP_ADDR; // host must slow down here
    end
  end
endmodule

// ===== test/scp_serial_port_properties.sv
// checker for the serial control port, bound to its ports
module scp_serial_port_properties
  import scp_pkg::*;
#(
  parameter int ADDR_BITS = SCP_ADDR_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic serial_frame_enable_n,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic alarm_serial_out,
  input wire logic alarmSerialOe,
  input wire logic four_wire_select,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [ADDR_BITS-1:0] regAddress,
  input wire logic frameActive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic sclkQ;
  logic [3:0] sinceFall;
  logic [3:0] sinceRise;
  logic seen;
  logic [ADDR_BITS-1:0] lastAddr;
  // cycles since the raw serial clock moved; saturates so old edges never count
  always_ff @(posedge clock) begin
    sclkQ <= serialClock;
    if (rst) sinceFall <= 4'hF;
    else if (sclkQ && !serialClock) sinceFall <= 4'h0;
    else if (sinceFall != 4'hF) sinceFall <= sinceFall + 4'h1;
    if (rst) sinceRise <= 4'hF;
    else if (!sclkQ && serialClock) sinceRise <= 4'h0;
    else if (sinceRise != 4'hF) sinceRise <= sinceRise + 4'h1;
  end
  // address of the previous access within the current frame
  always_ff @(posedge clock) begin
    if (rst || !frameActive) seen <= 1'b0;
    else if (regWrite || regRead) seen <= 1'b1;
    if (regWrite || regRead) lastAddr <= regAddress;
  end
  sequence frameClose;
    $rose(serial_frame_enable_n);
  endsequence
  sequence dataLaunch;
    $rose(serialDataOe) ##0 four_wire_select;
  endsequence
  AST_FRAME_DROP: assert property (frameClose |-> ##[1:12] !frameActive)
    else $error("frame still active after enable rose");
  AST_OE_RELEASE: assert property (frameClose |-> ##[1:12] !serialDataOe)
    else $error("data pin still driven after frame");
  AST_INSTR_INPUT: assert property ($rose(frameActive) |-> (!serialDataOe) [*8])
    else $error("data pin driven during instruction");
  AST_THREE_FLOAT: assert property (!four_wire_select && frameActive |-> !alarmSerialOe)
    else $error("alarm pin driven in three pin mode");
  AST_FOUR_MIRROR: assert property (dataLaunch |->
    ##[0:2] (alarmSerialOe && alarm_serial_out == serialDataOut))
    else $error("alarm pin does not carry read data");
  AST_ALARM_TAIL: assert property (frameClose ##0 four_wire_select ##0 serialDataOe
    |-> alarmSerialOe && !alarm_serial_out)
    else $error("alarm pin not low at frame end");
  AST_OUT_AFTER_FALL: assert property ($changed(serialDataOut) && serialDataOe
    && $past(serialDataOe) |-> sinceFall < 4'hA)
    else $error("read bit moved away from a falling edge");
  AST_WRITE_AFTER_RISE: assert property (regWrite |-> sinceRise < 4'hA && frameActive)
    else $error("write strobe away from a rising edge");
  AST_ADDR_DOWN: assert property ((regWrite || regRead) && seen
    |-> regAddress == lastAddr - SCP_ADDR_STEP)
    else $error("address did not count down");
endmodule
bind scp_serial_port scp_serial_port_properties #(.ADDR_BITS(ADDR_BITS))
  scp_serial_port_properties_i (.clock, .rst, .serialClock, .serial_frame_enable_n,
  .serialDataOut, .serialDataOe, .alarm_serial_out, .alarmSerialOe, .four_wire_select,
  .regWrite, .regRead, .regAddress, .frameActive);

// ===== test/scp_host_model.sv
// host side model: drives serial clock, frame enable and data pin
module scp_host_model (
  input wire logic clock,
  input wire logic sdio,
  input wire logic alarmPin,
  output logic serialClock,
  output logic frameEnN,
  output logic hostOut,
  output logic hostOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdA;
  logic [31:0] rdB;
  logic endLow;
  // serial clock stands high between frames
  initial begin
    serialClock = 1'b1;
    frameEnN = 1'b1;
    hostOut = 1'b0;
    hostOe = 1'b1;
  end
  task automatic waitCyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one frame; half is the half period in system cycles, bits may cut a byte short
  task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input int bits,
      input int half);
    int i;
    frameEnN = 1'b0;
    waitCyc(half);
    for (i = 0; i < 8 + bits; i++) begin
      serialClock = 1'b0;
      if (i < 8) hostOut = ins[7 - i];
      else hostOut = wd[39 - i];
      if (i == 8 && ins[7]) hostOe = 1'b0; // let go for read data
      waitCyc(half);
      serialClock = 1'b1;
      rdA = {rdA[30:0], sdio};
      rdB = {rdB[30:0], alarmPin};
      waitCyc(half);
    end
    serialClock = 1'b0;
    waitCyc(half);
    endLow = alarmPin;
    frameEnN = 1'b1;
    waitCyc(half);
    hostOe = 1'b1; // take the pin back only once the port has let go
    serialClock = 1'b1;
    waitCyc(4 * half);
  endtask
endmodule

// ===== test/test_scp_serial_port.sv
// testbench for the serial control port
module test_scp_serial_port
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] WD = 32'hC3A55A3C;
  logic clock, rst, serialClock, serial_frame_enable_n, serialDataIn, serialDataOut;
  logic serialDataOe, alarm_serial_out, alarmSerialOe, alarmLevel, four_wire_select;
  logic regWrite, regRead, frameActive, tempReadActive, hostOut, hostOe, noise;
  logic alarmPin, tempSeen;
  logic [4:0] regAddress;
  logic [7:0] regWriteData, regReadData;
  logic [12:0] wq[$];
  int fails, totalChecks, n;
  // undriven lines wander so a stale value is never read back
  assign serialDataIn = serialDataOe ? serialDataOut : (hostOe ? hostOut : noise);
  assign alarmPin = alarmSerialOe ? alarm_serial_out : ~noise;
  scp_serial_port scp_serial_port_i (.clock, .rst, .serialClock, .serial_frame_enable_n,
    .serialDataIn, .serialDataOut, .serialDataOe, .alarm_serial_out, .alarmSerialOe,
    .alarmLevel, .four_wire_select, .regWrite, .regRead, .regAddress, .regWriteData,
    .regReadData, .frameActive, .tempReadActive);
  scp_host_model scp_host_model_i (.clock, .sdio(serialDataIn), .alarmPin, .serialClock,
    .frameEnN(serial_frame_enable_n), .hostOut, .hostOe);
  function automatic logic [7:0] expRd(input logic [4:0] a);
    return {a, 3'h5};
  endfunction
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // register file stand-in: answers a read strobe within the next cycle
  always @(negedge clock) begin
    noise <= ~noise;
    if (regRead === 1'b1) regReadData <= expRd(regAddress);
  end
  always @(posedge clock) begin
    if (regWrite === 1'b1) wq.push_back({regAddress, regWriteData});
    if (tempReadActive === 1'b1) tempSeen <= 1'b1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic completeRun();
    if (fails == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------
  // tests: link runs two 64 ns half periods per bit, the temperature read 512 ns each; the sampler needs the margin
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    noise = 1'b0;
    alarmLevel = 1'b1;
    four_wire_select = 1'b0;
    regReadData = 8'h00;
    tempSeen = 1'b0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    for (n = 0; n < 4; n++) begin
      wq.delete();
      scp_host_model_i.frame({1'b0, 2'(n), 5'h0C}, WD, 8 * (n + 1), 16);
      chk("write count", n + 1, wq.size());
      foreach (wq[k]) chk("write entry", {5'h0C - 5'(k), WD[31 - 8 * k -: 8]}, wq[k]);
    end
    wq.delete();
    scp_host_model_i.frame(8'h01, 32'hF0000000, 4, 16);
    scp_host_model_i.frame(8'h02, 32'h69000000, 8, 16);
    chk("write after abort", 1, wq.size());
    chk("write after abort", {5'h02, 8'h69}, wq[0]);
    for (n = 0; n < 2; n++) begin
      four_wire_select = n[0];
      scp_host_model_i.frame(8'hB1, 32'h0, 16, 16);
      chk("read data pin", {expRd(5'h11), expRd(5'h10)}, scp_host_model_i.rdA[15:0]);
      if (n == 1) begin
        chk("read alarm pin", {expRd(5'h11), expRd(5'h10)}, scp_host_model_i.rdB[15:0]);
        chk("alarm tail", 1'b0, scp_host_model_i.endLow);
        chk("alarm idle", alarmLevel, alarmPin);
        alarmLevel = 1'b0;
        repeat (8) @(negedge clock);
        chk("alarm idle low", 1'b0, alarmPin);
        alarmLevel = 1'b1;
      end
    end
    chk("temperature flag idle", 1'b0, tempSeen);
    scp_host_model_i.frame({3'h4, SCP_TEMP_ADDR}, 32'h0, 8, 128);
    chk("temperature read", expRd(SCP_TEMP_ADDR), scp_host_model_i.rdA[7:0]);
    chk("temperature flag", 1'b1, tempSeen);
    completeRun();
  end
  // watchdog sized well past the longest expected run
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    completeRun();
  end
endmodule
